// file: bench/spr_meas_load.sv
/*
  Measurement source and relay load model beside the setpoint controller.
  Assumes the bench requests values and reads the counts of relay makes.
*/
`timescale 1ns/1ps
module spr_meas_load (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // Requests and relay coils
  input  wire logic [5:0][15:0] i_req,
  input  wire logic [5:0]       i_relay,
  // Register view and make counts
  output logic [5:0][15:0]      o_meas,
  output logic [5:0][7:0]       o_rises
);
  logic [5:0] prev;
  // Register fetch lands a cycle late, as a real source would
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_meas  <= '0;
      o_rises <= '0;
      prev    <= '0;
    end else begin
      o_meas <= i_req;
      prev   <= i_relay;
      for (int k = 0; k < 6; k++) begin
        if (i_relay[k] && !prev[k]) begin
          o_rises[k] <= o_rises[k] + 8'h01;
        end
      end
    end
  end
endmodule : spr_meas_load

// file: bench/test_spr_setpoint_relay.sv
/*
  Self-checking bench for the setpoint relay controller.
  Assumes a tick of four clocks and the measurement source model.
*/
`timescale 1ns/1ps
module test_spr_setpoint_relay;
  logic i_clk, i_resetn, i_ce, i_unlatch_pin, i_log_clear;
  logic [5:0][15:0] req, i_meas, i_setpoint, i_band, i_make_delay, i_break_delay, i_on_time, i_off_time;
  logic [5:0] i_ext_pin, i_src_ext, i_above, i_lvl2_en, i_lvl3_en, i_dev_inside, i_inhibit_en, i_inhibit_rising;
  logic [5:0] i_flash_en, i_track_en, i_latch_en, i_manual_reset, i_reset_en, i_log_en;
  logic [5:0][2:0] i_src_pin, i_timer_mode;
  logic [5:0][1:0] i_band_mode;
  logic [15:0] i_track_ref, i_pid_result_one, i_pid_result_two, o_loop_output_one, o_loop_output_two;
  logic [1:0] i_pid_relay;
  logic [5:0] o_relay, o_track_active, o_reg_reset, o_log_trig;
  logic o_flash, o_log_full;
  logic [11:0] o_log_count;
  logic [5:0][7:0] rises;
  int miscompares, n_compared, cycles, n, nt, nr;

  spr_setpoint_relay #(.TICK_CYCLES(18'h00004)) i_spr_setpoint_relay (.*);
  spr_meas_load i_spr_meas_load (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .i_relay(o_relay),
    .o_meas(i_meas), .o_rises(rises));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    nt += (o_log_trig[4] === 1'b1);
    nr += (o_reg_reset[4] === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic settle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic put(input int k, input logic [15:0] v);
    @(posedge i_clk);
    req[k] <= v;
  endtask : put
  // Bounded wait for a relay level, cycles counted
  task automatic wait_relay(input int k, input logic lv, output int c);
    c = 0;
    while (o_relay[k] !== lv && c < 200) begin
      settle(1);
      c++;
    end
  endtask : wait_relay
  task automatic run_seq(input int k, input logic [15:0] v [6], input logic [5:0] e, input logic fl);
    for (int i = 0; i < 6; i++) begin
      put(k, v[i]);
      settle(8);
      check("relay", o_relay[k], e[i]);
      if (fl) check("flash", o_flash, e[i]);
    end
  endtask : run_seq
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic t_inhibit;
    put(5, 16'h0096);
    settle(8);
    check("inhibit", o_relay[5], 1'b0);
    put(5, 16'h0032);
    settle(8);
    put(5, 16'h0096);
    settle(8);
    check("after inhibit", o_relay[5], 1'b1);
  endtask : t_inhibit
  task automatic t_hyst;
    @(posedge i_clk);
    {i_lvl2_en[2], i_flash_en[2], i_track_en[2]} <= 3'h7;
    i_band_mode[2] <= 2'h1;
    i_band[2] <= 16'h000a;
    settle(8);
    check("track", o_track_active[2], 1'b1);
    run_seq(2, '{16'h01fd, 16'h01fe, 16'h01eb, 16'h01ea, 16'h01e9, 16'h01fd}, 6'b001110, 1'b1);
    @(posedge i_clk);
    i_band_mode[2] <= 2'h0;
    settle(8);
    check("no track", o_track_active[2], 1'b0);
  endtask : t_hyst
  task automatic t_dev;
    @(posedge i_clk);
    {i_lvl2_en[3], i_dev_inside[3]} <= 2'h3;
    i_band_mode[3] <= 2'h2;
    i_setpoint[3] <= 16'h03e8;
    i_band[3] <= 16'h0023;
    run_seq(3, '{16'h03c4, 16'h03c5, 16'h03e8, 16'h040b, 16'h040c, 16'h03c4}, 6'b001110, 1'b0);
    i_dev_inside[3] <= 1'b0;
    run_seq(3, '{16'h03c4, 16'h03c5, 16'h03e8, 16'h040b, 16'h040c, 16'h03c4}, 6'b110001, 1'b0);
  endtask : t_dev
  task automatic t_latch;
    for (int j = 0; j < 2; j++) begin
      i_latch_en[0] <= 1'b1;
      put(0, 16'h0258);
      settle(6);
      put(0, 16'h0190);
      settle(6);
      check("latched", o_relay[0], 1'b1);
      if (j == 0) i_manual_reset[0] <= 1'b1;
      else i_unlatch_pin <= 1'b1;
      settle(8);
      check("unlatched", o_relay[0], 1'b0);
      {i_manual_reset[0], i_unlatch_pin} <= 2'h0;
    end
    i_latch_en[0] <= 1'b0;
  endtask : t_latch
  task automatic t_timers;
    logic [7:0] r0;
    i_lvl2_en[4] <= 1'b1;
    for (int m = 0; m < 7; m++) begin
      i_timer_mode[4] <= 3'(m);
      settle(8);
      check("rest level", o_relay[4], m >= 4);
    end
    i_timer_mode[4] <= 3'h0;
    {i_make_delay[4], i_break_delay[4], i_on_time[4], i_off_time[4]} <= {16'h3, 16'h2, 16'h1, 16'h1};
    put(4, 16'h0258);
    settle(6);
    put(4, 16'h0190);
    settle(2);
    put(4, 16'h0258);
    wait_relay(4, 1'b1, n);
    check("make delay", n >= 9 && n <= 22, 1'b1);
    put(4, 16'h0190);
    wait_relay(4, 1'b0, n);
    check("break delay", n >= 5 && n <= 16, 1'b1);
    i_timer_mode[4] <= 3'h1;
    r0 = rises[4];
    put(4, 16'h0258);
    settle(60);
    check("repeats", rises[4] - r0 >= 8'h04, 1'b1);
    put(4, 16'h0190);
    settle(8);
    {i_timer_mode[4], i_make_delay[4], i_on_time[4]} <= {3'h2, 16'h1, 16'h2};
    put(4, 16'h0258);
    wait_relay(4, 1'b1, n);
    wait_relay(4, 1'b0, n);
    check("pulse length", n >= 5 && n <= 14, 1'b1);
    put(4, 16'h0190);
    settle(8);
    {i_timer_mode[4], i_make_delay[4], i_on_time[4]} <= {3'h3, 16'h0, 16'h3};
    put(4, 16'h0258);
    wait_relay(4, 1'b1, n);
    put(4, 16'h0190);
    settle(8);
    check("min on", o_relay[4], 1'b1);
    wait_relay(4, 1'b0, n);
    check("one shot end", n <= 20, 1'b1);
    i_timer_mode[4] <= 3'h0;
  endtask : t_timers
  task automatic t_trig;
    {i_lvl3_en[4], i_log_en[4], i_reset_en[4], i_log_clear} <= 4'hf;
    settle(2);
    i_log_clear <= 1'b0;
    {nt, nr} = 0;
    put(4, 16'h0258);
    settle(8);
    check("log trig", nt, 1);
    check("reg reset", nr, 1);
    check("log count", o_log_count, 12'h001);
    check("log full", o_log_full, 1'b0);
    i_lvl3_en[4] <= 1'b0;
    put(4, 16'h0190);
    settle(8);
    put(4, 16'h0258);
    settle(8);
    check("no trig", nt, 1);
    put(4, 16'h0190);
  endtask : t_trig
  task automatic t_pin;
    {i_lvl2_en[4], i_src_ext[4], i_src_pin[4], i_ext_pin[3]} <= {1'b0, 1'b1, 3'h3, 1'b1};
    settle(8);
    check("pin high", o_relay[4], 1'b1);
    i_ext_pin[3] <= 1'b0;
    settle(8);
    check("pin low", o_relay[4], 1'b0);
    // Clock enable low freezes filter and relay
    i_ce <= 1'b0;
    i_ext_pin[3] <= 1'b1;
    settle(8);
    check("frozen", o_relay[4], 1'b0);
    i_ce <= 1'b1;
    settle(8);
    check("thawed", o_relay[4], 1'b1);
  endtask : t_pin
  task automatic t_loop;
    {i_lvl2_en[0], i_lvl2_en[2], i_pid_relay} <= 4'hf;
    {i_band_mode[0], i_band_mode[2]} <= 4'hf;
    {i_pid_result_one, i_pid_result_two} <= {16'h1234, 16'h8765};
    put(2, 16'h7000);
    settle(8);
    check("loop relay", o_relay[0], 1'b1);
    check("no loop relay", o_relay[2], 1'b0);
    check("loop one", o_loop_output_one, 16'h1234);
    check("loop two", o_loop_output_two, 16'h8765);
  endtask : t_loop

  initial begin
    {i_resetn, req, i_setpoint, i_band, i_make_delay, i_break_delay, i_on_time, i_off_time} = '0;
    {i_ext_pin, i_src_ext, i_lvl2_en, i_lvl3_en, i_dev_inside, i_inhibit_en, i_inhibit_rising} = '0;
    {i_flash_en, i_track_en, i_latch_en, i_manual_reset, i_reset_en, i_log_en, i_src_pin} = '0;
    {i_timer_mode, i_band_mode, i_track_ref, i_pid_result_one, i_pid_result_two, i_pid_relay} = '0;
    {i_unlatch_pin, i_log_clear, miscompares, n_compared, cycles, nt, nr} = '0;
    i_ce = 1'b1;
    i_above = 6'h3d;
    i_setpoint = {16'h0064, {5{16'h01f4}}};
    {i_lvl2_en[5], i_inhibit_en[5], i_inhibit_rising[5]} = 3'h7;
    i_band_mode[5] = 2'h1;
    settle(5);
    i_resetn <= 1'b1;
    t_inhibit();
    run_seq(0, '{16'h01f3, 16'h01f4, 16'h01f5, 16'h01f3, 16'h0258, 16'h0190}, 6'b010110, 1'b0);
    run_seq(1, '{16'h0258, 16'h0190, 16'h8000, 16'h7fff, 16'h0190, 16'h0258}, 6'b010110, 1'b0);
    t_hyst();
    t_dev();
    t_latch();
    put(4, 16'h0190);
    t_timers();
    t_trig();
    t_pin();
    t_loop();
    conclude();
  end
endmodule : test_spr_setpoint_relay

// file: hw/spr_consts.svh
/*
  Constants for the setpoint relay controller: counts, widths, timebase.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH
`define SPR_NUM_SP 6
`define SPR_NUM_PINS 6
`define SPR_VAL_W 16
`define SPR_CLK_MHZ 250
`define SPR_TICK_US 1000
`define SPR_TICK_CYCLES (`SPR_TICK_US * `SPR_CLK_MHZ)
`define SPR_TICK_W 18
`define SPR_LOG_DEPTH 12'hfa0
`define SPR_LOG_W 12
`define SPR_PID_SP_COUNT 2
`define SPR_LOOP_ONE_REG 50
`define SPR_LOOP_TWO_REG 51
`define SPR_MIN_DEV 16'h0001
`endif

// file: hw/spr_pkg.sv
/*
  Types for the setpoint relay controller: modes, timer states, state record.
  Assumes spr_consts.svh is on the include path.
*/
`include "spr_consts.svh"
package spr_pkg;
  typedef enum logic [1:0] {
    SPR_BAND_PLAIN = 2'h0,
    SPR_BAND_HYST  = 2'h1,
    SPR_BAND_DEV   = 2'h2,
    SPR_BAND_PID   = 2'h3
  } spr_band_t;
  typedef enum logic [2:0] {
    SPR_TM_NORMAL      = 3'h0,
    SPR_TM_REPEAT_ON   = 3'h1,
    SPR_TM_PULSE_ON    = 3'h2,
    SPR_TM_ONESHOT_ON  = 3'h3,
    SPR_TM_REPEAT_OFF  = 3'h4,
    SPR_TM_PULSE_OFF   = 3'h5,
    SPR_TM_ONESHOT_OFF = 3'h6
  } spr_tmode_t;
  typedef enum logic [3:0] {
    SPR_TS_IDLE  = 4'h1,
    SPR_TS_WAIT  = 4'h2,
    SPR_TS_ACT   = 4'h4,
    SPR_TS_BREAK = 4'h8
  } spr_tstate_t;
  typedef struct packed {
    logic [`SPR_NUM_PINS:0]                     s1;
    logic [`SPR_NUM_PINS:0]                     s2;
    logic [`SPR_NUM_PINS:0]                     s3;
    logic [`SPR_NUM_PINS:0]                     pin;
    logic [`SPR_TICK_W-1:0]                     tick_cnt;
    logic                                       tick;
    logic [`SPR_NUM_SP-1:0]                     act;
    spr_tstate_t [`SPR_NUM_SP-1:0]              tst;
    logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0]     cnt;
    logic [`SPR_NUM_SP-1:0]                     relay;
    logic [`SPR_NUM_SP-1:0]                     latched;
    logic [`SPR_NUM_SP-1:0]                     inh_done;
    logic [`SPR_NUM_SP-1:0]                     track;
    logic [`SPR_NUM_SP-1:0]                     reg_reset;
    logic [`SPR_NUM_SP-1:0]                     log_trig;
    logic                                       flash;
    logic [`SPR_LOG_W-1:0]                      log_cnt;
    logic                                       log_full;
    logic [`SPR_VAL_W-1:0]                      loop_one;
    logic [`SPR_VAL_W-1:0]                      loop_two;
  } spr_state_t;
endpackage : spr_pkg

// file: hw/spr_setpoint_relay.sv
/*
  Six-setpoint relay controller: compare, bands, timers, latching, triggers.
  Assumes measurement values already selected per setpoint, pins raw/async.
*/
`timescale 1ns/1ps
`include "spr_consts.svh"
module spr_setpoint_relay #(
  parameter logic [`SPR_TICK_W-1:0] TICK_CYCLES = `SPR_TICK_W'(`SPR_TICK_CYCLES)
) (
  // Clock, reset, enable
  input  wire logic                                   i_clk,
  input  wire logic                                   i_resetn,
  input  wire logic                                   i_ce,
  // Sources
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_meas,
  input  wire logic [`SPR_NUM_PINS-1:0]               i_ext_pin,
  input  wire logic                                   i_unlatch_pin,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_src_ext,
  input  wire logic [`SPR_NUM_SP-1:0][2:0]            i_src_pin,
  // Compare and band setup
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_setpoint,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_above,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_lvl2_en,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_lvl3_en,
  input  wire logic [`SPR_NUM_SP-1:0][1:0]            i_band_mode,
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_band,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_dev_inside,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_inhibit_en,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_inhibit_rising,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_flash_en,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_track_en,
  input  wire logic [`SPR_VAL_W-1:0]                  i_track_ref,
  // Timers
  input  wire logic [`SPR_NUM_SP-1:0][2:0]            i_timer_mode,
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_make_delay,
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_break_delay,
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_on_time,
  input  wire logic [`SPR_NUM_SP-1:0][`SPR_VAL_W-1:0] i_off_time,
  // Latch, reset and trigger
  input  wire logic [`SPR_NUM_SP-1:0]                 i_latch_en,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_manual_reset,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_reset_en,
  input  wire logic [`SPR_NUM_SP-1:0]                 i_log_en,
  input  wire logic                                   i_log_clear,
  // Loop control
  input  wire logic [`SPR_PID_SP_COUNT-1:0]           i_pid_relay,
  input  wire logic [`SPR_VAL_W-1:0]                  i_pid_result_one,
  input  wire logic [`SPR_VAL_W-1:0]                  i_pid_result_two,
  // Outputs
  output logic [`SPR_NUM_SP-1:0]                      o_relay,
  output logic                                        o_flash,
  output logic [`SPR_NUM_SP-1:0]                      o_track_active,
  output logic [`SPR_NUM_SP-1:0]                      o_reg_reset,
  output logic [`SPR_NUM_SP-1:0]                      o_log_trig,
  output logic [`SPR_LOG_W-1:0]                       o_log_count,
  output logic                                        o_log_full,
  output logic [`SPR_VAL_W-1:0]                       o_loop_output_one,
  output logic [`SPR_VAL_W-1:0]                       o_loop_output_two
);

  spr_pkg::spr_state_t st;
  spr_pkg::spr_state_t next_st;

  always_comb begin
    logic signed [17:0] x;
    logic signed [17:0] sp;
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    logic [15:0]        bnd;
    logic [15:0]        wdly;
    logic [15:0]        len;
    spr_pkg::spr_band_t   bm;
    spr_pkg::spr_tmode_t  tm;
    spr_pkg::spr_tstate_t ts;
    spr_pkg::spr_tstate_t nts;
    logic               a;
    logic               lvl2;
    logic               inv;
    logic               pulse;
    logic               raw;
    logic               lat;
    logic [`SPR_LOG_W-1:0] lbase;
    x = '0;
    sp = '0;
    lo = '0;
    hi = '0;
    bnd = '0;
    wdly = '0;
    len = '0;
    bm = spr_pkg::SPR_BAND_PLAIN;
    tm = spr_pkg::SPR_TM_NORMAL;
    ts = spr_pkg::SPR_TS_IDLE;
    nts = spr_pkg::SPR_TS_IDLE;
    a = 1'b0;
    lvl2 = 1'b0;
    inv = 1'b0;
    pulse = 1'b0;
    raw = 1'b0;
    lat = 1'b0;
    lbase = '0;
    next_st = st;
    // Three-stage pin filter; level taken once stages two and three agree
    next_st.s1 = {i_unlatch_pin, i_ext_pin};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int p = 0; p <= `SPR_NUM_PINS; p++) begin
      if (st.s2[p] == st.s3[p]) begin
        next_st.pin[p] = st.s3[p];
      end
    end
    next_st.tick = 1'b0;
    if (st.tick_cnt >= TICK_CYCLES - 1'b1) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
    end
    // results of registers 50 and 51
    next_st.loop_one = i_pid_result_one;
    next_st.loop_two = i_pid_result_two;
    next_st.flash = 1'b0;
    for (int k = 0; k < `SPR_NUM_SP; k++) begin
      lvl2 = i_lvl2_en[k];
      // level two off forces basic compare
      bm = lvl2 ? spr_pkg::spr_band_t'(i_band_mode[k]) : spr_pkg::SPR_BAND_PLAIN;
      next_st.track[k] = i_track_en[k] && (bm != spr_pkg::SPR_BAND_PLAIN);
      sp = 18'($signed(i_setpoint[k]));
      if (next_st.track[k]) begin
        sp = sp + 18'($signed(i_track_ref));
      end
      // band width, deviation never below one count
      bnd = (bm == spr_pkg::SPR_BAND_PLAIN) ? 16'h0000 : i_band[k];
      if (bm == spr_pkg::SPR_BAND_DEV && bnd < `SPR_MIN_DEV) begin
        bnd = `SPR_MIN_DEV;
      end
      lo = sp - $signed({2'h0, bnd});
      hi = sp + $signed({2'h0, bnd});
      x = 18'($signed(i_meas[k]));
      if (i_src_ext[k]) begin
        a = (i_src_pin[k] < 3'h6) ? (st.pin[i_src_pin[k]] ~^ i_above[k]) : 1'b0;
      end else begin
        case (bm)
          spr_pkg::SPR_BAND_DEV: begin
            a = ((x >= lo) && (x <= hi)) ~^ i_dev_inside[k];
          end
          // loop relay on first two only
          spr_pkg::SPR_BAND_PID: begin
            a = (k < `SPR_PID_SP_COUNT) ? i_pid_relay[k % `SPR_PID_SP_COUNT] : 1'b0;
          end
          default: begin
            if (i_above[k]) begin
              a = st.act[k] ? (x >= lo) : (x >= hi);
            end else begin
              a = st.act[k] ? (x <= hi) : (x <= lo);
            end
          end
        endcase
      end
      next_st.act[k] = a;
      // inhibit ends once the first activation drops, if direction matches
      next_st.inh_done[k] = st.inh_done[k] | !(lvl2 && i_inhibit_en[k] && (i_inhibit_rising[k] == i_above[k]))
                            | (st.act[k] & !a);
      tm = lvl2 ? spr_pkg::spr_tmode_t'(i_timer_mode[k]) : spr_pkg::SPR_TM_NORMAL;
      inv = (tm >= spr_pkg::SPR_TM_REPEAT_OFF) && (tm <= spr_pkg::SPR_TM_ONESHOT_OFF);
      len = inv ? i_off_time[k] : i_on_time[k];
      if (tm == spr_pkg::SPR_TM_REPEAT_ON || tm == spr_pkg::SPR_TM_REPEAT_OFF) begin
        wdly = inv ? i_on_time[k] : i_off_time[k];
      end else begin
        wdly = inv ? i_break_delay[k] : i_make_delay[k];
      end
      ts = st.tst[k];
      nts = ts;
      case (ts)
        spr_pkg::SPR_TS_IDLE: begin
          if (a) begin
            nts = spr_pkg::SPR_TS_WAIT;
          end
        end
        spr_pkg::SPR_TS_WAIT: begin
          if (!a) begin
            nts = spr_pkg::SPR_TS_IDLE;
          end else if (st.cnt[k] >= wdly) begin
            nts = spr_pkg::SPR_TS_ACT;
          end
        end
        spr_pkg::SPR_TS_ACT: begin
          case (tm)
            spr_pkg::SPR_TM_REPEAT_ON, spr_pkg::SPR_TM_REPEAT_OFF: begin
              if (!a) begin
                nts = spr_pkg::SPR_TS_IDLE;
              end else if (st.cnt[k] >= len) begin
                nts = spr_pkg::SPR_TS_WAIT;
              end
            end
            spr_pkg::SPR_TM_PULSE_ON, spr_pkg::SPR_TM_PULSE_OFF: begin
              if (!a) begin
                nts = spr_pkg::SPR_TS_IDLE;
              end else if (st.cnt[k] >= len) begin
                nts = spr_pkg::SPR_TS_BREAK;
              end
            end
            spr_pkg::SPR_TM_ONESHOT_ON, spr_pkg::SPR_TM_ONESHOT_OFF: begin
              if (!a && st.cnt[k] >= len) begin
                nts = spr_pkg::SPR_TS_IDLE;
              end
            end
            default: begin
              if (!a) begin
                nts = spr_pkg::SPR_TS_BREAK;
              end
            end
          endcase
        end
        spr_pkg::SPR_TS_BREAK: begin
          if (tm != spr_pkg::SPR_TM_NORMAL) begin
            if (!a) begin
              nts = spr_pkg::SPR_TS_IDLE;
            end
          end else if (a) begin
            nts = spr_pkg::SPR_TS_ACT;
          end else if (st.cnt[k] >= i_break_delay[k]) begin
            nts = spr_pkg::SPR_TS_IDLE;
          end
        end
        default: begin
          nts = spr_pkg::SPR_TS_IDLE;
        end
      endcase
      next_st.tst[k] = nts;
      // restart on state or activation change
      if (nts != ts || a != st.act[k]) begin
        next_st.cnt[k] = '0;
      end else if (st.tick && st.cnt[k] != 16'hffff) begin
        next_st.cnt[k] = st.cnt[k] + 1'b1;
      end
      pulse = (nts == spr_pkg::SPR_TS_ACT) || (tm == spr_pkg::SPR_TM_NORMAL && nts == spr_pkg::SPR_TS_BREAK);
      // timers bypassed when level two is off
      raw = lvl2 ? (pulse ^ inv) : a;
      raw = raw & st.inh_done[k];
      lat = (st.latched[k] & !(i_manual_reset[k] | st.pin[`SPR_NUM_PINS])) | (i_latch_en[k] & raw);
      next_st.latched[k] = lat;
      next_st.relay[k] = raw | lat;
      if (lvl2 && i_flash_en[k] && a && (bm == spr_pkg::SPR_BAND_HYST || bm == spr_pkg::SPR_BAND_DEV)) begin
        next_st.flash = 1'b1;
      end
      // activation edge actions need level three
      next_st.reg_reset[k] = a & !st.act[k] & lvl2 & i_lvl3_en[k] & i_reset_en[k];
      next_st.log_trig[k] = a & !st.act[k] & lvl2 & i_lvl3_en[k] & i_log_en[k];
    end
    // sample count saturates at depth; a new sample beats the clear
    lbase = i_log_clear ? '0 : st.log_cnt;
    if (|next_st.log_trig && lbase != `SPR_LOG_DEPTH) begin
      lbase = lbase + 1'b1;
    end
    next_st.log_cnt = lbase;
    next_st.log_full = (lbase == `SPR_LOG_DEPTH);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.tst <= {`SPR_NUM_SP{spr_pkg::SPR_TS_IDLE}};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_relay           = st.relay;
  assign o_flash           = st.flash;
  assign o_track_active    = st.track;
  assign o_reg_reset       = st.reg_reset;
  assign o_log_trig        = st.log_trig;
  assign o_log_count       = st.log_cnt;
  assign o_log_full        = st.log_full;
  assign o_loop_output_one = st.loop_one;
  assign o_loop_output_two = st.loop_two;

  a_log_cap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    st.log_cnt <= `SPR_LOG_DEPTH) else $error("log count above depth");
  a_loop_regs: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce |=> o_loop_output_two == $past(i_pid_result_two)) else $error("loop result not held");

  for (genvar g = 0; g < `SPR_NUM_SP; g++) begin : g_chk
    sequence s_rise;
      !st.act[g] ##1 st.act[g];
    endsequence
    sequence s_plain_above;
      i_ce && !i_src_ext[g] && i_lvl2_en[g] && i_band_mode[g] == 2'h1 && i_band[g] == 16'h0000
        && i_above[g] && !i_track_en[g];
    endsequence
    a_hyst_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_plain_above and ($signed(i_meas[g]) >= $signed(i_setpoint[g])) |=> st.act[g])
      else $error("zero band not active at setpoint");
    a_dev_inside: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && !i_src_ext[g] && i_lvl2_en[g] && i_band_mode[g] == 2'h2 && i_dev_inside[g] && !i_track_en[g]
       && i_band[g] != 16'h0000 && $signed(i_meas[g]) == $signed(i_setpoint[g])) |=> st.act[g])
      else $error("deviation centre not active");
    a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st.latched[g] && !i_manual_reset[g] && !st.pin[`SPR_NUM_PINS]) |=> st.relay[g])
      else $error("latched relay released");
    a_inhibit_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && !st.inh_done[g] && !st.latched[g]) |=> !st.relay[g]) else $error("relay on while inhibited");
    a_timer_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_rise |-> st.cnt[g] == 16'h0000) else $error("timer not restarted");
    a_trig_edge: assert property (@(posedge i_clk) disable iff (!i_resetn)
      st.log_trig[g] |-> st.act[g] && $past(!st.act[g])) else $error("trigger without activation edge");
    a_track_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && i_band_mode[g] == 2'h0) |=> !st.track[g]) else $error("tracking in basic mode");
    if (g >= `SPR_PID_SP_COUNT) begin : g_pid
      a_pid_first: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && !i_src_ext[g] && i_lvl2_en[g] && i_band_mode[g] == 2'h3 && i_timer_mode[g] == 3'h0
         && !st.latched[g] && !st.act[g]) |=> !st.relay[g]) else $error("loop relay on later setpoint");
    end
  end

endmodule : spr_setpoint_relay
